/* File: hdl/object_server.v */
// Service data object server: message interpreter and register port.
`timescale 1ns/1ps
`include "object_server_defines.vh"

// Overview of operation
// - Serve messages only in preop, safeop, op
// - Abort: command 4, selector, 4-byte code
// - Absent index aborts with 06020000
// - Absent nonzero sub-index aborts with 08000000
// - Unsupported command byte aborts with 05040001
// - Download access errors abort 06020000/06010002
// - Normal sized download length mismatch aborts
// - Expedited sized download size mismatch aborts
// - Failed store aborts with its own code
// - Wrong segment toggle aborts with 06020000
// - Early last segment aborts with 06020000
// - Foreign non-abort message mid-download aborts 05040001
// - Segment request 0, reply 1, seven bytes
// - Toggle starts 0, alternates, reply echoes it
// - Upload access errors abort 06020000/06010001
// - Failed short read aborts with its code
// - Upload request and reply command 2
// - Normal upload size little-endian bytes 4-7
// - Unused count only when expedited and sized
// - Unused and reserved bits sent as zero
// - Replies response type, aborts request type
module object_server (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        rx_valid,
  input  wire [63:0] rx_data,
  output reg         rx_ready,
  output reg         tx_valid,
  output reg  [63:0] tx_data,
  output reg         tx_response,
  output reg         dict_req,
  output reg  [15:0] dict_index,
  output reg  [7:0]  dict_sub,
  input  wire        dict_ack,
  input  wire        dict_idx_found,
  input  wire        dict_sub_found,
  input  wire        dict_acc_none,
  input  wire        dict_acc_rd,
  input  wire        dict_acc_wr,
  input  wire [31:0] dict_size,
  output reg         store_req,
  output reg  [55:0] store_data,
  output reg  [2:0]  store_len,
  output reg         store_last,
  input  wire        store_done,
  input  wire        store_fail,
  input  wire [31:0] store_code,
  output reg         load_req,
  input  wire        load_done,
  input  wire        load_fail,
  input  wire [31:0] load_code,
  input  wire [31:0] load_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg  [3:0]  link_state_request_reg;
  reg  [31:0] last_abort;
  reg  [2:0]  state;
  reg  [63:0] msg;
  reg  [23:0] xfer_mux;
  reg         seg_active;
  reg         exp_toggle;
  reg  [31:0] rcv_count;
  reg  [31:0] xfer_size;

  wire [2:0]  ccs      = msg[7:5];
  wire        seg_t    = msg[4];
  wire [2:0]  seg_n    = msg[3:1];
  wire        seg_c    = msg[0];
  wire [1:0]  ini_n    = msg[3:2];
  wire        ini_e    = msg[1];
  wire        ini_s    = msg[0];
  wire [2:0]  seg_len  = `SEG_MAX_BYTES - seg_n;
  wire [2:0]  exp_len  = `EXP_MAX_BYTES - {1'b0, ini_n};
  wire [31:0] seg_sum  = rcv_count + {29'h0, seg_len};
  wire        size_big = dict_size > {29'h0, `EXP_MAX_BYTES};
  // Taken from the captured size: the lookup result is gone by now
  wire [2:0]  up_n     = `EXP_MAX_BYTES - xfer_size[2:0];

  wire link_ok = (link_state_request_reg == `LINK_PREOP) ||
                 (link_state_request_reg == `LINK_SAFEOP) ||
                 (link_state_request_reg == `LINK_OP);

  // ---------------------------------------------------------------
  // Limitations
  // ---------------------------------------------------------------
  // Segment data beyond the announced size is passed to the store
  // side unchecked; the store side may refuse it with its own code.
  // Uploads longer than four bytes get a sized reply only; the
  // upload segments that would follow are refused as commands.
  // Link state values other than the three serving encodings serve nothing.
  // An abort from the client is never answered; it only clears the
  // transfer in progress.

  // ---------------------------------------------------------------
  // Request checks
  // ---------------------------------------------------------------
  // Sub-index 0 names the entry count and is never refused
  wire        sub_missing  = (msg[31:24] != 8'h00) &&
                             !dict_sub_found;
  wire        norm_len_bad = ini_s &&
                             (msg[63:32] != dict_size);
  wire        exp_len_bad  = ini_s &&
                             (size_big ||
                              ({29'h0, exp_len} != dict_size));
  wire        tgl_bad      = (seg_t != exp_toggle);
  wire        seg_short    = seg_c &&
                             (seg_sum < xfer_size);
  wire        seg_foreign  = (ccs != `CCS_DN_SEGMENT);
  wire        init_cmd     = (ccs == `CCS_INIT_DN) ||
                             (ccs == `CCS_INIT_UP);
  // An unsized expedited write stores what fits four bytes; the
  // client then owns any mismatch with the entry size
  wire [2:0]  exp_store    = ini_s ? exp_len :
                             (size_big ? `EXP_MAX_BYTES :
                              dict_size[2:0]);

  // ---------------------------------------------------------------
  // Answer words
  // ---------------------------------------------------------------
  // X and reserved bits of every command byte are tied to zero
  wire [7:0]  abort_cmd    = {`CCS_ABORT, 5'h00};
  wire [7:0]  dn_init_cmd  = {`SCS_INIT_DN, 5'h00};
  wire [7:0]  dn_seg_cmd   = {`SCS_DN_SEGMENT, seg_t,
                              4'h0};
  wire [7:0]  up_size_cmd  = {`SCS_INIT_UP, 5'h01};
  wire [7:0]  up_exp_cmd   = {`SCS_INIT_UP, 1'b0, up_n[1:0],
                              2'h3};
  // Mid-download the abort names the running transfer, not the
  // stray message that caused it
  wire [23:0] abort_sel    = seg_active ? xfer_mux : msg[31:8];
  // Clears the high bytes a short entry does not fill
  wire [31:0] up_mask      = ~(32'hFFFFFFFF <<
                               {xfer_size[2:0], 3'h0});
  wire [63:0] dn_init_word = {32'h0, msg[31:8], dn_init_cmd};
  wire [63:0] dn_seg_word  = {56'h0, dn_seg_cmd};
  wire [63:0] up_size_word = {dict_size, msg[31:8],
                              up_size_cmd};
  wire [63:0] up_exp_word  = {load_data & up_mask, msg[31:8],
                              up_exp_cmd};

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  wire [31:0] status_word  = {26'h0, rx_ready, seg_active, exp_toggle,
                              state};

  // ---------------------------------------------------------------
  // Answer helpers
  // ---------------------------------------------------------------
  task send_abort;
    input [31:0] code;
    begin
      tx_data     <= {code, abort_sel, abort_cmd};
      tx_response <= 1'b0;
      tx_valid    <= 1'b1;
      last_abort  <= code;
      seg_active  <= 1'b0;
      exp_toggle  <= 1'b0;
      state       <= `ST_IDLE;
      rx_ready    <= 1'b1;
    end
  endtask

  task send_reply;
    input [63:0] data;
    begin
      tx_data     <= data;
      tx_response <= 1'b1;
      tx_valid    <= 1'b1;
      state       <= `ST_IDLE;
      rx_ready    <= 1'b1;
    end
  endtask

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Read data live for one cycle only, zero otherwise, so a bus
  // fabric may OR several slaves together
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_state_request_reg <= `LINK_RESET_VAL;
      reg_rdata              <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `REG_LINK_STATE)
        link_state_request_reg <= reg_wdata[3:0];
      if (reg_rd) begin
        case (reg_addr)
          `REG_LINK_STATE: reg_rdata <= {28'h0, link_state_request_reg};
          `REG_STATUS:     reg_rdata <= status_word;
          `REG_LAST_ABORT: reg_rdata <= last_abort;
          default:         reg_rdata <= 32'h00000000;
        endcase
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Message engine
  // ---------------------------------------------------------------
  // IDLE    waits for a frame while the link serves
  // DECODE  sorts client aborts, segments and initiates
  // LOOKUP  waits for the dictionary verdict on the selector
  // STORE   waits for the write of one expedited word or segment
  // LOAD    waits for the read of a short entry
  // No path out of LOOKUP, STORE or LOAD raises rx_ready again without an answer, so a
  // lost dictionary answer stalls the link until reset; the client
  // side is expected to time out.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state       <= `ST_IDLE;
      msg         <= 64'h0000000000000000;
      xfer_mux    <= 24'h000000;
      seg_active  <= 1'b0;
      exp_toggle  <= 1'b0;
      rcv_count   <= 32'h00000000;
      xfer_size   <= 32'h00000000;
      last_abort  <= 32'h00000000;
      rx_ready    <= 1'b1;
      tx_valid    <= 1'b0;
      tx_data     <= 64'h0000000000000000;
      tx_response <= 1'b0;
      dict_req    <= 1'b0;
      dict_index  <= 16'h0000;
      dict_sub    <= 8'h00;
      store_req   <= 1'b0;
      store_data  <= 56'h00000000000000;
      store_len   <= 3'h0;
      store_last  <= 1'b0;
      load_req    <= 1'b0;
    end else begin
      tx_valid  <= 1'b0;
      dict_req  <= 1'b0;
      store_req <= 1'b0;
      load_req  <= 1'b0;
      case (state)
        `ST_IDLE: begin
          // Frames outside the serving states get no answer
          if (rx_valid && rx_ready && link_ok) begin
            msg      <= rx_data;
            rx_ready <= 1'b0;
            state    <= `ST_DECODE;
          end
        end
        `ST_DECODE: begin
          if (ccs == `CCS_ABORT) begin
            // Abort from the client: silent drop, no answer
            seg_active <= 1'b0;
            exp_toggle <= 1'b0;
            state      <= `ST_IDLE;
            rx_ready   <= 1'b1;
          end else if (seg_active) begin
            if (seg_foreign)
              send_abort(`ABT_CMD_ERROR);
            else if (tgl_bad)
              send_abort(`ABT_NO_OBJECT);
            else if (seg_short)
              send_abort(`ABT_NO_OBJECT);
            else begin
              store_req  <= 1'b1;
              store_data <= msg[63:8];
              store_len  <= seg_len;
              store_last <= seg_c;
              state      <= `ST_STORE;
            end
          end else if (init_cmd) begin
            dict_req   <= 1'b1;
            dict_index <= msg[23:8];
            dict_sub   <= msg[31:24];
            state      <= `ST_LOOKUP;
          end else begin
            send_abort(`ABT_CMD_ERROR);
          end
        end
        `ST_LOOKUP: begin
          if (dict_ack) begin
            if (!dict_idx_found)
              send_abort(`ABT_NO_OBJECT);
            else if (sub_missing)
              send_abort(`ABT_NO_SUBINDEX);
            else if (dict_acc_none)
              send_abort(`ABT_NO_OBJECT);
            else if (ccs == `CCS_INIT_DN) begin
              if (!dict_acc_wr)
                send_abort(`ABT_READ_ONLY);
              else if (!ini_e) begin
                if (norm_len_bad)
                  send_abort(`ABT_TYPE_LENGTH);
                else begin
                  seg_active <= 1'b1;
                  exp_toggle <= 1'b0;
                  rcv_count  <= 32'h00000000;
                  xfer_size  <= dict_size;
                  xfer_mux   <= msg[31:8];
                  send_reply(dn_init_word);
                end
              end else if (exp_len_bad)
                send_abort(`ABT_TYPE_LENGTH);
              else begin
                store_req  <= 1'b1;
                store_data <= {24'h000000, msg[63:32]};
                store_len  <= exp_store;
                store_last <= 1'b1;
                state      <= `ST_STORE;
              end
            end else begin
              if (!dict_acc_rd)
                send_abort(`ABT_WRITE_ONLY);
              else if (!size_big) begin
                load_req  <= 1'b1;
                xfer_size <= dict_size;
                state     <= `ST_LOAD;
              end else begin
                // Normal sized reply: byte count, LSB in byte 4
                send_reply(up_size_word);
              end
            end
          end
        end
        `ST_STORE: begin
          if (store_done) begin
            if (store_fail)
              send_abort(store_code);
            else if (seg_active) begin
              rcv_count  <= seg_sum;
              exp_toggle <= ~exp_toggle;
              if (store_last)
                seg_active <= 1'b0;
              // Reply echoes toggle, rest reserved zero
              send_reply(dn_seg_word);
            end else begin
              send_reply(dn_init_word);
            end
          end
        end
        `ST_LOAD: begin
          if (load_done) begin
            if (load_fail)
              send_abort(load_code);
            else
              // Expedited sized reply; unused high bytes zeroed
              send_reply(up_exp_word);
          end
        end
        default: begin
          state    <= `ST_IDLE;
          rx_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // object_server

/* File: hdl/object_server_defines.vh */
// Constants for the service data object server engine.
`ifndef OBJECT_SERVER_DEFINES_VH
`define OBJECT_SERVER_DEFINES_VH

// Abort codes
`define ABT_NO_OBJECT    32'h06020000
`define ABT_NO_SUBINDEX  32'h08000000
`define ABT_CMD_ERROR    32'h05040001
`define ABT_WRITE_ONLY   32'h06010001
`define ABT_READ_ONLY    32'h06010002
`define ABT_TYPE_LENGTH  32'h06070010

// Command specifiers, byte 0 bits 7:5
`define CCS_DN_SEGMENT   3'h0
`define CCS_INIT_DN      3'h1
`define CCS_INIT_UP      3'h2
`define CCS_ABORT        3'h4
`define SCS_DN_SEGMENT   3'h1
`define SCS_INIT_UP      3'h2
`define SCS_INIT_DN      3'h3

// Payload limits in bytes
`define EXP_MAX_BYTES    3'h4
`define SEG_MAX_BYTES    3'h7

// Link states written by software
`define LINK_INIT        4'h1
`define LINK_PREOP       4'h2
`define LINK_SAFEOP      4'h4
`define LINK_OP          4'h8
`define LINK_RESET_VAL   4'h1

// Register offsets
`define REG_LINK_STATE   4'h0
`define REG_STATUS       4'h4
`define REG_LAST_ABORT   4'h8

// Engine states
`define ST_IDLE          3'h0
`define ST_DECODE        3'h1
`define ST_LOOKUP        3'h2
`define ST_STORE         3'h3
`define ST_LOAD          3'h4

`endif

/* File: verif/object_server_checker.sv */
// Port assertions for the object server message engine.
`timescale 1ns/1ps
module object_server_checker (
  input wire        ref_clk,
  input wire        rst,
  input wire        rx_valid,
  input wire [63:0] rx_data,
  input wire        rx_ready,
  input wire        tx_valid,
  input wire [63:0] tx_data,
  input wire        tx_response,
  input wire        dict_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reg  tgl;
  wire ab = tx_valid && tx_data[7:5] == 3'h4;
  wire sg = tx_valid && tx_data[7:5] == 3'h1;
  wire up = tx_valid && tx_data[7:5] == 3'h2;
  // Toggle of the last taken message, for the echo
  always @(posedge ref_clk) if (rx_valid && rx_ready) tgl <= rx_data[4];
  AST_ABORT_TYPE: assert property (ab |-> !tx_response)
    else $error("abort sent as response type");
  AST_REPLY_TYPE: assert property (tx_valid && !ab |-> tx_response)
    else $error("reply sent as request type");
  AST_ABORT_BYTE0: assert property (ab |-> tx_data[4:0] == 5'h0)
    else $error("abort command byte not clean");
  AST_SEG_ECHO: assert property (sg |-> tx_data[4] == tgl)
    else $error("segment reply toggle not echoed");
  AST_SEG_ZERO: assert property (sg |-> tx_data[63:8] == 56'h0)
    else $error("segment reply unused bytes not zero");
  AST_UP_UNUSED: assert property (up && tx_data[1:0] != 2'h3 |->
    tx_data[3:2] == 2'h0)
    else $error("unused count set without e and s");
  AST_ONE_ANSWER: assert property (tx_valid |-> $rose(rx_ready))
    else $error("answer without closing a request");
  AST_TAKE_ONLY: assert property ($fell(rx_ready) |-> $past(rx_valid))
    else $error("ready dropped without a message");
  AST_ANSWER_BOUND: assert property ($fell(rx_ready) |->
    ##[1:300] $rose(rx_ready))
    else $error("request never closed");
  AST_LOOKUP_BUSY: assert property (dict_req |-> !rx_ready)
    else $error("lookup while idle");
  cover property (ab);
  cover property (sg);
  cover property (up);
endmodule // object_server_checker

/* File: verif/dict_partner.sv */
// Dictionary, store and load responder beside the object server.
`timescale 1ns/1ps
module dict_partner (
  input  wire        ref_clk,
  input  wire        dict_req,
  input  wire        store_req,
  input  wire        load_req,
  output wire        dict_ack,
  output wire        dict_idx_found,
  output wire        dict_sub_found,
  output wire        dict_acc_none,
  output wire        dict_acc_rd,
  output wire        dict_acc_wr,
  output wire [31:0] dict_size,
  output wire        store_done,
  output wire        store_fail,
  output wire [31:0] store_code,
  output wire        load_done,
  output wire        load_fail,
  output wire [31:0] load_code,
  output wire [31:0] load_data
);
  // ----
  // Knobs set by the bench
  // ----
  reg [4:0]  attr  = 5'h1B; // Found, sub, none, rd, wr
  reg [31:0] size  = 32'h2;
  reg        fail  = 1'b0;  // Failure code path
  reg [31:0] code  = 32'h06040047;
  reg [31:0] value = 32'hA5A5BEEF;
  integer    lat   = 0;
  reg [3:0]  dp    = 4'h0;
  reg [3:0]  sp    = 4'h0;
  reg [3:0]  lp    = 4'h0;
  always @(posedge ref_clk) begin
    dp <= {dp[2:0], dict_req};
    sp <= {sp[2:0], store_req};
    lp <= {lp[2:0], load_req};
  end
  assign dict_ack   = dp[lat];
  assign store_done = sp[lat];
  assign load_done  = lp[lat];
  // Results outside their pulse are scrambled, never held
  assign {dict_idx_found, dict_sub_found, dict_acc_none, dict_acc_rd,
          dict_acc_wr} = dict_ack ? attr : ~attr;
  assign dict_size  = dict_ack ? size : ~size;
  assign store_fail = store_done ? fail : ~fail;
  assign store_code = store_done ? code : ~code;
  assign load_fail  = load_done ? fail : ~fail;
  assign load_code  = load_done ? code : ~code;
  assign load_data  = load_done ? value : ~value;
endmodule // dict_partner

/* File: verif/object_server_test.sv */
// Self-checking bench for the object server message engine.
`timescale 1ns/1ps
`include "object_server_defines.vh"
module object_server_test;
  logic        ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_valid = 0;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, dict_size, store_code;
  logic [31:0] load_code, load_data;
  logic [63:0] rx_data = 0, tx_data;
  logic        rx_ready, tx_valid, tx_response, dict_req, dict_ack;
  logic        dict_idx_found, dict_sub_found, dict_acc_none, dict_acc_rd;
  logic        dict_acc_wr, store_req, store_last, store_done, store_fail;
  logic        load_req, load_done, load_fail;
  logic [15:0] dict_index;
  logic [7:0]  dict_sub;
  logic [55:0] store_data;
  logic [2:0]  store_len;
  integer      bad_count = 0, cmp_count = 0, i;
  localparam logic [23:0] S = 24'h012345;
  localparam logic [63:0] UP = {32'h0, S, 8'h40};
  localparam logic [63:0] DN = {32'h9, S, 8'h21};
  localparam logic [63:0] SEG = {56'h11223344556677, 8'h00};
  localparam logic [63:0] OKD = {32'h0, S, 8'h60};
  localparam logic [63:0] OKS = {56'h0, 8'h20};
  object_server dut_u (.*);
  dict_partner  p_u (.*);
  always #4 ref_clk = ~ref_clk;
  // ----
  // Access tasks
  // ----
  function automatic logic [63:0] ab(input logic [31:0] c);
    return {c, S, 8'h80};
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(input logic [4:0] a, input logic [31:0] s,
                     input logic f, input integer l);
    p_u.attr = a;
    p_u.size = s;
    p_u.fail = f;
    p_u.lat = l;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", {32'h0, e}, {32'h0, reg_rdata});
  endtask
  task automatic xfer(input logic [63:0] m, e, input logic ans);
    integer n;
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data <= m;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 50);
    rx_valid <= 1'b0;
    rx_data <= ~m;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (tx_valid !== 1'b1 && n < (ans ? 300 : 30));
    chk("tx_valid", {63'h0, ans}, {63'h0, tx_valid});
    if (ans) begin
      chk("tx_data", e, tx_data);
      chk("tx_response", {63'h0, e[7:5] != 3'h4}, {63'h0, tx_response});
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rreg(4'h0, 32'h1);
    rreg(4'hC, 32'h0);
    xfer(UP, 0, 0);
    for (i = 0; i < 3; i++) begin
      wreg(4'h0, 32'h2 << i);
      xfer(UP, {32'hBEEF, S, 8'h4B}, 1);
    end
    cfg(5'h0B, 2, 0, 1);
    xfer(UP, ab(`ABT_NO_OBJECT), 1);
    chk("dict_sel", {dict_sub, dict_index}, S);
    cfg(5'h13, 2, 0, 0);
    xfer(UP, ab(`ABT_NO_SUBINDEX), 1);
    xfer({32'h0, 24'h002345, 8'h40}, {32'hBEEF, 24'h002345, 8'h4B}, 1);
    cfg(5'h1F, 2, 0, 0);
    xfer(UP, ab(`ABT_NO_OBJECT), 1);
    xfer(DN, ab(`ABT_NO_OBJECT), 1);
    cfg(5'h19, 2, 0, 0);
    xfer(UP, ab(`ABT_WRITE_ONLY), 1);
    cfg(5'h1A, 2, 0, 0);
    xfer(DN, ab(`ABT_READ_ONLY), 1);
    cfg(5'h1B, 2, 1, 2);
    xfer(UP, ab(p_u.code), 1);
    xfer({32'h1234, S, 8'h2B}, ab(p_u.code), 1);
    cfg(5'h1B, 32'h12345, 0, 2);
    xfer(UP, {32'h12345, S, 8'h41}, 1);
    for (i = 0; i < 8; i++)
      if (i != 1 && i != 2 && i != 4)
        xfer({32'h0, S, i[2:0], 5'h0}, ab(`ABT_CMD_ERROR), 1);
    cfg(5'h1B, 6, 0, 0);
    xfer({32'h5, S, 8'h21}, ab(`ABT_TYPE_LENGTH), 1);
    cfg(5'h1B, 4, 0, 0);
    xfer({32'h1234, S, 8'h2B}, ab(`ABT_TYPE_LENGTH), 1);
    cfg(5'h1B, 8, 0, 0);
    xfer({32'h1234, S, 8'h23}, ab(`ABT_TYPE_LENGTH), 1);
    cfg(5'h1B, 2, 0, 1);
    xfer({32'h1234, S, 8'h2B}, OKD, 1);
    chk("store", {store_len, store_last, store_data},
        {3'h2, 1'b1, 56'h1234});
    cfg(5'h1B, 9, 0, 2);
    xfer(DN, OKD, 1);
    xfer(SEG, OKS, 1);
    xfer(SEG, ab(`ABT_NO_OBJECT), 1);
    xfer(DN, OKD, 1);
    xfer(SEG, OKS, 1);
    xfer(UP, ab(`ABT_CMD_ERROR), 1);
    xfer(DN, OKD, 1);
    xfer(SEG, OKS, 1);
    xfer({56'h1, 8'h1D}, ab(`ABT_NO_OBJECT), 1);
    xfer(DN, OKD, 1);
    xfer(SEG, OKS, 1);
    xfer(ab(32'h0800_0000), 0, 0);
    xfer(SEG, {`ABT_CMD_ERROR, 24'h556677, 8'h80}, 1);
    wreg(4'h8, 32'h0);
    rreg(4'h8, `ABT_CMD_ERROR);
    xfer(DN, OKD, 1);
    xfer(SEG, OKS, 1);
    xfer({56'h2, 8'h1B}, {56'h0, 8'h30}, 1);
    chk("store", {store_len, store_last, store_data},
        {3'h2, 1'b1, 56'h2});
    wreg(4'h0, 32'h1);
    xfer(UP, 0, 0);
    give_verdict;
  end
  initial begin
    #400000;
    bad_count++;
    give_verdict;
  end
endmodule // object_server_test
bind object_server object_server_checker chk_u (.*);
